// *** rtl/fmu_pkg.sv ***
// Constants, register map and types of the four-channel frequency measurement unit.
// Assumes a 25 MHz system clock and a 12-bit word-aligned register port.
package fmu_pkg;

	// Clock and channel geometry
	localparam int CLK_PERIOD_NS = 40;
	localparam int NUM_CH        = 4;
	localparam int NUM_DI        = 16;
	localparam int CH_PIN [4]    = '{1, 4, 7, 10};

	// Register offsets
	localparam logic [11:0] ADDR_CH0_VALUE  = 12'h330;
	localparam logic [11:0] ADDR_CH1_VALUE  = 12'h334;
	localparam logic [11:0] ADDR_CH2_VALUE  = 12'h338;
	localparam logic [11:0] ADDR_CH3_VALUE  = 12'h33c;
	localparam logic [11:0] ADDR_CH0_CFG    = 12'h340;
	localparam logic [11:0] ADDR_IRQ_SEL    = 12'h350;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h354;

	// Field positions
	localparam int CFG_ITIME_LSB = 0;
	localparam int CFG_FSEL_LSB  = 16;
	localparam int CFG_IRQEN_BIT = 24;
	localparam int CFG_GATE_BIT  = 25;
	localparam int CFG_PWM_BIT   = 26;
	localparam int STAT_PEND_LSB = 0;
	localparam int STAT_LOST_LSB = 4;
	localparam int STAT_RUN_LSB  = 8;

	// Times and derived cycle counts
	localparam int MS_NS      = 1000000;
	localparam int MS_CYCLES  = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PW_1K_NS   = 400000;
	localparam int PW_2K_NS   = 200000;
	localparam int PW_5K_NS   = 80000;
	localparam int PW_10K_NS  = 40000;
	localparam int PW_30K_NS  = 13000;
	localparam int PW_60K_NS  = 6700;
	localparam int PW_1K_CYC  = (PW_1K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PW_2K_CYC  = (PW_2K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PW_5K_CYC  = (PW_5K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PW_10K_CYC = (PW_10K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PW_30K_CYC = (PW_30K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PW_60K_CYC = (PW_60K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Integration time limits in milliseconds
	localparam logic [13:0] ITIME_MIN_MS     = 14'h000a;
	localparam logic [13:0] ITIME_MAX_MS     = 14'h2710;
	localparam logic [13:0] ITIME_DEFAULT_MS = 14'h0064;

	// Arithmetic
	localparam logic [39:0] MHZ_SCALE     = 40'h00000f4240;
	localparam logic [19:0] EDGE_CNT_MAX  = 20'hfffff;
	localparam logic [5:0]  DIV_LAST_STEP = 6'h27;

	typedef enum logic [2:0] {
		FSEL_1K  = 3'h0,
		FSEL_2K  = 3'h1,
		FSEL_5K  = 3'h2,
		FSEL_10K = 3'h3,
		FSEL_30K = 3'h4,
		FSEL_60K = 3'h5
	} fsel_t;

	typedef enum logic [1:0] {
		IRQ_NONE         = 2'h0,
		IRQ_PROCESS      = 2'h1,
		IRQ_DIAG_PROCESS = 2'h2
	} irq_sel_t;

	typedef struct packed {
		logic        pwm_active;
		logic        software_gate;
		logic        irq_enable;
		fsel_t       max_freq;
		logic [13:0] itime_ms;
	} chan_cfg_t;

	localparam chan_cfg_t CFG_RESET = '{pwm_active: 1'b0, software_gate: 1'b0,
		irq_enable: 1'b0, max_freq: FSEL_60K, itime_ms: ITIME_DEFAULT_MS};

endpackage

// *** rtl/freq_channel.sv ***
// One measurement channel: pulse width filter, edge counting window and mHz divider.
// Assumes a synchronised pulse input and a one-cycle millisecond tick from the top.
`timescale 1ns/1ps
module freq_channel (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Timing and configuration
	input  wire logic              ms_tick_i,
	input  wire fmu_pkg::chan_cfg_t cfg_i,
	input  wire logic [13:0]       min_pw_i,
	// Measured signal
	input  wire logic              pulse_i,
	// Results
	output logic                   done_o,
	output logic [31:0]            result_o,
	output logic                   running_o
);

	typedef enum logic {
		DIV_IDLE = 1'b0,
		DIV_BUSY = 1'b1
	} div_state_t;

	div_state_t  div_state_r;
	logic        en_q_r;
	logic        filt_r;
	logic [13:0] pw_cnt_r;
	logic [13:0] ms_cnt_r;
	logic [19:0] edge_cnt_r;
	logic [39:0] dvd_r;
	logic [13:0] divisor_r;
	logic [13:0] rem_r;
	logic [5:0]  step_r;
	logic [31:0] result_r;
	logic        done_r;
	logic        enable;
	logic        active;
	logic        pw_ok;
	logic        rise;
	logic        win_end;
	logic [14:0] trial;
	logic        q_bit;

	assign enable  = cfg_i.software_gate && !cfg_i.pwm_active;
	assign active  = enable && en_q_r;
	assign pw_ok   = pw_cnt_r >= (min_pw_i - 14'h0001);
	assign rise    = pulse_i && !filt_r && pw_ok;
	assign win_end = active && ms_tick_i && ((ms_cnt_r + 14'h0001) >= cfg_i.itime_ms);
	assign trial   = {rem_r, dvd_r[39]};
	assign q_bit   = trial >= {1'b0, divisor_r};

	// Gate edge detection restarts the window when counting is enabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_q_r <= 1'b0;
		end else begin
			en_q_r <= enable;
		end
	end

	// Pulse shorter than the minimum width is rejected
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			filt_r   <= 1'b0;
			pw_cnt_r <= 14'h0000;
		end else if (pulse_i == filt_r) begin
			pw_cnt_r <= 14'h0000;
		end else if (pw_ok) begin
			filt_r   <= pulse_i;
			pw_cnt_r <= 14'h0000;
		end else begin
			pw_cnt_r <= pw_cnt_r + 14'h0001;
		end
	end

	// Integration window in milliseconds
	always_ff @(posedge clk_i) begin
		if (rst_i || !active) begin
			ms_cnt_r <= 14'h0000;
		end else if (win_end) begin
			ms_cnt_r <= 14'h0000;
		end else if (ms_tick_i) begin
			ms_cnt_r <= ms_cnt_r + 14'h0001;
		end
	end

	// Rising edge count of the filtered signal
	always_ff @(posedge clk_i) begin
		if (rst_i || !active) begin
			edge_cnt_r <= 20'h00000;
		end else if (win_end) begin
			edge_cnt_r <= {19'h00000, rise};
		end else if (rise && edge_cnt_r != fmu_pkg::EDGE_CNT_MAX) begin
			edge_cnt_r <= edge_cnt_r + 20'h00001;
		end
	end

	// Edges times 1e6 over window ms gives millihertz
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_state_r <= DIV_IDLE;
			dvd_r       <= 40'h0000000000;
			divisor_r   <= fmu_pkg::ITIME_DEFAULT_MS;
			rem_r       <= 14'h0000;
			step_r      <= 6'h00;
			result_r    <= 32'h00000000;
			done_r      <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (!active) begin
				div_state_r <= DIV_IDLE;
			end else if (win_end) begin
				div_state_r <= DIV_BUSY;
				dvd_r       <= 40'(40'(edge_cnt_r) * fmu_pkg::MHZ_SCALE);
				divisor_r   <= cfg_i.itime_ms;
				rem_r       <= 14'h0000;
				step_r      <= 6'h00;
			end else begin
				unique case (div_state_r)
					DIV_IDLE: begin
						step_r <= 6'h00;
					end
					DIV_BUSY: begin
						rem_r  <= q_bit ? 14'(trial - {1'b0, divisor_r}) : trial[13:0];
						dvd_r  <= {dvd_r[38:0], q_bit};
						step_r <= step_r + 6'h01;
						if (step_r == fmu_pkg::DIV_LAST_STEP) begin
							div_state_r <= DIV_IDLE;
							result_r    <= {dvd_r[30:0], q_bit};
							done_r      <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	chk_result_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!done_r |-> $stable(result_r))
		else $error("result changed without a finished measurement");

	assign done_o    = done_r;
	assign result_o  = result_r;
	assign running_o = en_q_r;

endmodule

// *** rtl/frequency_measurement_unit.sv ***
// Top of the four-channel frequency measurement unit with its register port.
// Assumes single-cycle read/write strobes and raw digital input pins.
//
// Notes on behaviour
// - The latest result of channels 0 to 3 reads as unsigned words from 0x330 to 0x33c.
// - Interrupt selection none raises neither hardware nor diagnostic interrupts.
// - Process selection with a channel enabled raises a hardware interrupt per measurement.
// - Diagnostics selection raises a diagnostic interrupt only for a lost hardware interrupt.
// - Integration time per channel is 10 to 10000 ms in 1 ms steps, 100 ms after reset.
// - A selectable maximum frequency, 60 kHz after reset, sets the shortest accepted pulse.
// - The end-of-measurement interrupt is disabled after reset until software enables it.
// - Channels 0 to 3 take their signal from input bits 1, 4, 7 and 10.
// - Each input indicator is lit while its input is one and dark while it is zero.
// - The result is published only once a whole integration time has elapsed; the first window after counting starts can be up to 1 ms short.
// - A window without a rising edge publishes zero.
// - The published frequency is in millihertz.
// - Counting on a channel stops while PWM is active on that channel.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module frequency_measurement_unit #(
	parameter int MS_CYCLES_P = fmu_pkg::MS_CYCLES,
	parameter int PW_1K_CYC_P = fmu_pkg::PW_1K_CYC,
	parameter int PW_2K_CYC_P = fmu_pkg::PW_2K_CYC
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Register port
	input  wire logic [11:0] addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// Digital input pins and indicators
	input  wire logic [15:0] di_i,
	output logic      [15:0] led_o,
	// Interrupts
	output logic             hw_irq_o,
	output logic             diag_irq_o
);

	fmu_pkg::chan_cfg_t cfg_r [fmu_pkg::NUM_CH];
	fmu_pkg::irq_sel_t  irq_sel_r;
	logic [15:0]        di_s1_r;
	logic [15:0]        di_s2_r;
	logic [15:0]        led_r;
	logic [14:0]        tick_cnt_r;
	logic               ms_tick_r;
	logic [3:0]         pend_r;
	logic [3:0]         lost_r;
	logic [31:0]        rdata_r;
	logic               hw_irq_r;
	logic               diag_irq_r;
	logic [3:0]         done;
	logic [3:0]         running;
	logic [31:0]        result [fmu_pkg::NUM_CH];
	logic [13:0]        min_pw [fmu_pkg::NUM_CH];
	logic [3:0]         set_pend;
	logic [3:0]         set_lost;
	logic [3:0]         clr_pend;
	logic [3:0]         clr_lost;
	logic               sel_active;
	logic               sel_diag;
	logic               stat_wr;
	logic [31:0]        rdata_nxt;

	assign sel_active = (irq_sel_r == fmu_pkg::IRQ_PROCESS) ||
		(irq_sel_r == fmu_pkg::IRQ_DIAG_PROCESS);
	assign sel_diag   = irq_sel_r == fmu_pkg::IRQ_DIAG_PROCESS;
	assign stat_wr    = wr_i && addr_i == fmu_pkg::ADDR_IRQ_STATUS;
	assign clr_pend   = stat_wr ? wdata_i[fmu_pkg::STAT_PEND_LSB +: 4] : 4'h0;
	assign clr_lost   = stat_wr ? wdata_i[fmu_pkg::STAT_LOST_LSB +: 4] : 4'h0;

	function automatic logic [13:0] clamp_itime(input logic [13:0] v);
		if (v < fmu_pkg::ITIME_MIN_MS) begin
			return fmu_pkg::ITIME_MIN_MS;
		end else if (v > fmu_pkg::ITIME_MAX_MS) begin
			return fmu_pkg::ITIME_MAX_MS;
		end
		return v;
	endfunction

	function automatic logic [13:0] pulse_cycles(input fmu_pkg::fsel_t f);
		unique case (f)
			fmu_pkg::FSEL_1K:  return 14'(PW_1K_CYC_P);
			fmu_pkg::FSEL_2K:  return 14'(PW_2K_CYC_P);
			fmu_pkg::FSEL_5K:  return 14'(fmu_pkg::PW_5K_CYC);
			fmu_pkg::FSEL_10K: return 14'(fmu_pkg::PW_10K_CYC);
			fmu_pkg::FSEL_30K: return 14'(fmu_pkg::PW_30K_CYC);
			default:           return 14'(fmu_pkg::PW_60K_CYC);
		endcase
	endfunction

	// Two-stage input synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			di_s1_r <= 16'h0000;
			di_s2_r <= 16'h0000;
		end else begin
			di_s1_r <= di_i;
			di_s2_r <= di_s1_r;
		end
	end

	// Input indicators follow the synchronised levels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			led_r <= 16'h0000;
		end else begin
			led_r <= di_s2_r;
		end
	end

	// Millisecond tick shared by all channels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_r <= 15'h0000;
			ms_tick_r  <= 1'b0;
		end else if (tick_cnt_r == 15'(MS_CYCLES_P - 1)) begin
			tick_cnt_r <= 15'h0000;
			ms_tick_r  <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 15'h0001;
			ms_tick_r  <= 1'b0;
		end
	end

	// Interrupt selection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_sel_r <= fmu_pkg::IRQ_NONE;
		end else if (wr_i && addr_i == fmu_pkg::ADDR_IRQ_SEL) begin
			irq_sel_r <= fmu_pkg::irq_sel_t'(wdata_i[1:0]);
		end
	end

	generate
		for (genvar i = 0; i < fmu_pkg::NUM_CH; i++) begin : g_ch
			// Per-channel configuration word
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					cfg_r[i] <= fmu_pkg::CFG_RESET;
				end else if (wr_i && addr_i == fmu_pkg::ADDR_CH0_CFG + 12'(4 * i)) begin
					cfg_r[i].itime_ms <= clamp_itime(wdata_i[fmu_pkg::CFG_ITIME_LSB +: 14]);
					cfg_r[i].max_freq <= (wdata_i[fmu_pkg::CFG_FSEL_LSB +: 3] > 3'h5) ?
						fmu_pkg::FSEL_60K : fmu_pkg::fsel_t'(wdata_i[fmu_pkg::CFG_FSEL_LSB +: 3]);
					cfg_r[i].irq_enable    <= wdata_i[fmu_pkg::CFG_IRQEN_BIT];
					cfg_r[i].software_gate <= wdata_i[fmu_pkg::CFG_GATE_BIT];
					cfg_r[i].pwm_active    <= wdata_i[fmu_pkg::CFG_PWM_BIT];
				end
			end

			assign min_pw[i] = pulse_cycles(cfg_r[i].max_freq);

			// Pending set and loss detection, set wins over acknowledge
			assign set_pend[i] = done[i] && cfg_r[i].irq_enable && sel_active;
			assign set_lost[i] = set_pend[i] && sel_diag && pend_r[i] && !clr_pend[i];

			freq_channel u_chan (
				.clk_i     (clk_i),
				.rst_i     (rst_i),
				.ms_tick_i (ms_tick_r),
				.cfg_i     (cfg_r[i]),
				.min_pw_i  (min_pw[i]),
				.pulse_i   (di_s2_r[fmu_pkg::CH_PIN[i]]),
				.done_o    (done[i]),
				.result_o  (result[i]),
				.running_o (running[i])
			);

			chk_pend_set: assert property (@(posedge clk_i) disable iff (rst_i)
				done[i] && cfg_r[i].irq_enable && sel_active |=> pend_r[i])
				else $error("finished measurement left no pending bit");

			chk_lost_set: assert property (@(posedge clk_i) disable iff (rst_i)
				done[i] && cfg_r[i].irq_enable && sel_diag && pend_r[i] && !clr_pend[i]
				|=> lost_r[i])
				else $error("lost interrupt not recorded");

			chk_pend_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
				!cfg_r[i].irq_enable && !pend_r[i] |=> !pend_r[i])
				else $error("pending bit set while interrupt disabled");

			chk_run_gated: assert property (@(posedge clk_i) disable iff (rst_i)
				running[i] |-> $past(cfg_r[i].software_gate && !cfg_r[i].pwm_active))
				else $error("channel runs without open gate");

			chk_itime_bound: assert property (@(posedge clk_i) disable iff (rst_i)
				cfg_r[i].itime_ms >= fmu_pkg::ITIME_MIN_MS &&
				cfg_r[i].itime_ms <= fmu_pkg::ITIME_MAX_MS)
				else $error("integration time out of range");

			chk_fsel_legal: assert property (@(posedge clk_i) disable iff (rst_i)
				cfg_r[i].max_freq <= fmu_pkg::FSEL_60K)
				else $error("maximum frequency select out of range");
		end
	endgenerate

	// Sticky pending and lost flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_r <= 4'h0;
			lost_r <= 4'h0;
		end else begin
			pend_r <= (pend_r & ~clr_pend) | set_pend;
			lost_r <= (lost_r & ~clr_lost) | set_lost;
		end
	end

	// Interrupt outputs gated by the selection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hw_irq_r   <= 1'b0;
			diag_irq_r <= 1'b0;
		end else begin
			hw_irq_r   <= sel_active && (|pend_r);
			diag_irq_r <= sel_diag && (|lost_r);
		end
	end

	// Read decode, unmapped addresses read zero
	always_comb begin
		rdata_nxt = 32'h00000000;
		unique case (addr_i)
			fmu_pkg::ADDR_CH0_VALUE:  rdata_nxt = result[0];
			fmu_pkg::ADDR_CH1_VALUE:  rdata_nxt = result[1];
			fmu_pkg::ADDR_CH2_VALUE:  rdata_nxt = result[2];
			fmu_pkg::ADDR_CH3_VALUE:  rdata_nxt = result[3];
			fmu_pkg::ADDR_CH0_CFG:    rdata_nxt = 32'(cfg_r[0]);
			fmu_pkg::ADDR_CH0_CFG + 12'h004: rdata_nxt = 32'(cfg_r[1]);
			fmu_pkg::ADDR_CH0_CFG + 12'h008: rdata_nxt = 32'(cfg_r[2]);
			fmu_pkg::ADDR_CH0_CFG + 12'h00c: rdata_nxt = 32'(cfg_r[3]);
			fmu_pkg::ADDR_IRQ_SEL:    rdata_nxt = {30'h00000000, irq_sel_r};
			fmu_pkg::ADDR_IRQ_STATUS: rdata_nxt = {20'h00000, running, lost_r, pend_r};
			default:                  rdata_nxt = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_r <= 32'h00000000;
		end else begin
			rdata_r <= rd_i ? rdata_nxt : 32'h00000000;
		end
	end

	assign rdata_o    = rdata_r;
	assign led_o      = led_r;
	assign hw_irq_o   = hw_irq_r;
	assign diag_irq_o = diag_irq_r;

	chk_none_no_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_sel_r == fmu_pkg::IRQ_NONE |=> !hw_irq_o && !diag_irq_o)
		else $error("interrupt raised with selection none");

	chk_done_sets_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		done[0] && cfg_r[0].irq_enable && irq_sel_r == fmu_pkg::IRQ_PROCESS
		|=> pend_r[0] ##1 hw_irq_o)
		else $error("finished measurement did not raise hardware interrupt");

	chk_lost_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(lost_r[0]) |-> $past(done[0] && pend_r[0] && sel_diag))
		else $error("lost flag set without a lost interrupt");

	chk_itime_range: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_r[1].itime_ms >= fmu_pkg::ITIME_MIN_MS && cfg_r[1].itime_ms <= fmu_pkg::ITIME_MAX_MS)
		else $error("integration time out of range");

	chk_irq_en_reset: assert property (@(posedge clk_i)
		$fell(rst_i) |-> !cfg_r[0].irq_enable && !cfg_r[3].irq_enable && !hw_irq_o)
		else $error("end of measurement interrupt enabled after reset");

	chk_led_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i, 1) && !$past(rst_i, 2) && !$past(rst_i, 3) |-> led_o == $past(di_i, 3))
		else $error("indicator does not follow input");

	chk_read_value: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == fmu_pkg::ADDR_CH2_VALUE |=> rdata_o == $past(result[2]))
		else $error("channel 2 value not returned");

	chk_pwm_stops: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_r[1].pwm_active [*2] |-> !running[1] && !done[1])
		else $error("channel counts during pwm");

	chk_gate_closed: assert property (@(posedge clk_i) disable iff (rst_i)
		!cfg_r[2].software_gate |=> !running[2])
		else $error("channel runs with gate closed");

	chk_read_ch0: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == fmu_pkg::ADDR_CH0_VALUE |=> rdata_o == $past(result[0]))
		else $error("channel 0 value not returned");

	chk_read_ch1: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == fmu_pkg::ADDR_CH1_VALUE |=> rdata_o == $past(result[1]))
		else $error("channel 1 value not returned");

	chk_read_ch3: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == fmu_pkg::ADDR_CH3_VALUE |=> rdata_o == $past(result[3]))
		else $error("channel 3 value not returned");

	chk_read_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		!rd_i |=> rdata_o == 32'h00000000)
		else $error("read data outside the read cycle");

	chk_none_no_pend: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_sel_r == fmu_pkg::IRQ_NONE
		|=> (pend_r & ~$past(pend_r)) == 4'h0)
		else $error("pending set with selection none");

	chk_none_no_lost: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_sel_r == fmu_pkg::IRQ_NONE
		|=> (lost_r & ~$past(lost_r)) == 4'h0)
		else $error("lost set with selection none");

	chk_process_no_diag: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_sel_r == fmu_pkg::IRQ_PROCESS |=> !diag_irq_o)
		else $error("diagnostic interrupt under process selection");

	chk_diag_needs_lost: assert property (@(posedge clk_i) disable iff (rst_i)
		diag_irq_o |-> $past(sel_diag && lost_r != 4'h0))
		else $error("diagnostic interrupt without a lost interrupt");

	chk_hw_needs_pend: assert property (@(posedge clk_i) disable iff (rst_i)
		hw_irq_o |-> $past(sel_active && pend_r != 4'h0))
		else $error("hardware interrupt without a pending bit");

	chk_tick_single: assert property (@(posedge clk_i) disable iff (rst_i)
		ms_tick_r |=> !ms_tick_r)
		else $error("millisecond tick longer than one cycle");

	chk_sel_write: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == fmu_pkg::ADDR_IRQ_SEL
		|=> irq_sel_r == $past(wdata_i[1:0]))
		else $error("interrupt selection not taken");

	chk_status_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		stat_wr && wdata_i[fmu_pkg::STAT_PEND_LSB] && !set_pend[0]
		|=> !pend_r[0])
		else $error("pending bit not cleared");

	chk_gate_write: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == fmu_pkg::ADDR_CH0_CFG
		|=> cfg_r[0].software_gate == $past(wdata_i[fmu_pkg::CFG_GATE_BIT]))
		else $error("software gate not taken");

endmodule

// *** sim/pulse_source.sv ***
// Model of the external pulse sources wired to the digital input pins.
// Assumes the bench sets each channel's period and high time in clock cycles.
`timescale 1ns/1ps
module pulse_source (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Control from the bench
	input  wire logic [3:0]       en_i,
	input  wire logic [3:0][11:0] period_i,
	input  wire logic [3:0][11:0] high_i,
	input  wire logic [15:0]      static_i,
	// Input pins
	output logic      [15:0]      di_o
);
	logic [3:0][11:0] cnt_r;
	logic [3:0]       pin_r;

	// Periodic pulse per channel, low while disabled
	always_ff @(posedge clk_i) begin
		for (int c = 0; c < 4; c++) begin
			if (rst_i || !en_i[c] || cnt_r[c] >= period_i[c] - 12'h001) begin
				cnt_r[c] <= 12'h000;
			end else begin
				cnt_r[c] <= cnt_r[c] + 12'h001;
			end
			pin_r[c] <= en_i[c] && (cnt_r[c] < high_i[c]);
		end
	end

	// Slow levels elsewhere, pulses on the counter B inputs
	always_comb begin
		di_o = static_i;
		for (int c = 0; c < 4; c++) begin
			di_o[fmu_pkg::CH_PIN[c]] = pin_r[c];
		end
	end
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the frequency measurement unit.
// Assumes short millisecond and filter counts set by parameters below.
`timescale 1ns/1ps
module tb;
	localparam int MS  = 25;
	localparam int WIN = 100 * MS;
	logic             clk_i   = 1'b0;
	logic             rst_i   = 1'b1;
	logic [11:0]      addr_i  = 12'h000;
	logic [31:0]      wdata_i = 32'h00000000;
	logic             wr_i    = 1'b0;
	logic             rd_i    = 1'b0;
	logic [31:0]      rdata_o;
	logic [15:0]      di_i;
	logic [15:0]      led_o;
	logic             hw_irq_o;
	logic             diag_irq_o;
	logic [3:0]       en      = 4'h0;
	logic [3:0][11:0] per     = {12'h9c4, 12'h4e2, 12'h271, 12'h1f4};
	logic [3:0][11:0] hi      = {12'h4b0, 12'h258, 12'h12c, 12'h0fa};
	logic [15:0]      st      = 16'hf00f;
	logic [31:0]      d;
	int               mismatches = 0;
	int               compares   = 0;

	always #20 clk_i = ~clk_i;

	frequency_measurement_unit #(.MS_CYCLES_P(MS), .PW_1K_CYC_P(40), .PW_2K_CYC_P(20)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .di_i(di_i), .led_o(led_o), .hw_irq_o(hw_irq_o),
		.diag_irq_o(diag_irq_o));

	pulse_source src (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .period_i(per), .high_i(hi),
		.static_i(st), .di_o(di_i));

	function automatic logic [11:0] va(int c);
		return fmu_pkg::ADDR_CH0_VALUE + 12'(4 * c);
	endfunction

	function automatic logic [11:0] ca(int c);
		return fmu_pkg::ADDR_CH0_CFG + 12'(4 * c);
	endfunction

	function automatic logic [31:0] cw(logic [13:0] t, logic [2:0] f, logic q, logic g, logic p);
		return {5'h00, p, g, q, 5'h00, f, 2'h0, t};
	endfunction

	function automatic logic [31:0] cr(logic [13:0] t, logic [2:0] f, logic q, logic g, logic p);
		return {12'h000, p, g, q, f, t};
	endfunction

	task automatic wr(logic [11:0] a, logic [31:0] v);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
	endtask

	task automatic rd(logic [11:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic rchk(logic [11:0] a, logic [31:0] e, string m);
		rd(a);
		chk(d, e, m);
	endtask

	task automatic results();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20 * WIN) @(posedge clk_i);
		mismatches++;
		results();
	end

	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int c = 0; c < 4; c++) begin
			rchk(va(c), 32'h00000000, "value after reset");
			rchk(ca(c), cr(fmu_pkg::ITIME_DEFAULT_MS, 3'h5, 0, 0, 0), "cfg reset");
		end
		rchk(12'h3f0, 32'h00000000, "unmapped read");
		chk({30'h0, hw_irq_o, diag_irq_o}, 32'h00000000, "irq after reset");
		$display("test reset done");

		repeat (5) @(posedge clk_i);
		chk({16'h0000, led_o}, {16'h0000, st & 16'hfb6d}, "indicators");
		st <= 16'h0ff0;
		repeat (5) @(posedge clk_i);
		chk({16'h0000, led_o}, {16'h0000, 16'h0b60}, "indicators");
		$display("test indicators done");

		wr(ca(3), cw(14'h0005, 3'h5, 0, 0, 0));
		rchk(ca(3), cr(fmu_pkg::ITIME_MIN_MS, 3'h5, 0, 0, 0), "itime low clamp");
		wr(ca(3), cw(14'h3fff, 3'h5, 0, 0, 0));
		rchk(ca(3), cr(fmu_pkg::ITIME_MAX_MS, 3'h5, 0, 0, 0), "itime high clamp");
		wr(ca(3), cw(14'h0064, 3'h5, 0, 0, 0));
		rchk(ca(3), cr(14'h0064, 3'h5, 0, 0, 0), "itime step");
		$display("test itime done");

		en <= 4'hf;
		wr(fmu_pkg::ADDR_IRQ_SEL, 32'h00000001);
		for (int c = 0; c < 4; c++) wr(ca(c), cw(14'h0064, 3'h5, 0, 1, 0));
		repeat (2 * WIN + 300) @(posedge clk_i);
		for (int c = 0; c < 4; c++) begin
			rchk(va(c), 32'(WIN / int'(per[c]) * 1000000 / 100), "frequency");
		end
		chk({31'h0, hw_irq_o}, 32'h00000000, "irq still disabled");
		$display("test measure done");

		wr(ca(0), cw(14'h0064, 3'h5, 1, 1, 0));
		wr(fmu_pkg::ADDR_IRQ_STATUS, 32'h000000ff);
		for (int i = 0; i < WIN + 200 && hw_irq_o !== 1'b1; i++) @(posedge clk_i);
		chk({31'h0, hw_irq_o}, 32'h00000001, "end of measurement irq");
		repeat (WIN + 100) @(posedge clk_i);
		chk({31'h0, diag_irq_o}, 32'h00000000, "no diag under process");
		wr(fmu_pkg::ADDR_IRQ_SEL, 32'h00000002);
		for (int i = 0; i < WIN + 200 && diag_irq_o !== 1'b1; i++) @(posedge clk_i);
		chk({31'h0, diag_irq_o}, 32'h00000001, "lost irq diag");
		rd(fmu_pkg::ADDR_IRQ_STATUS);
		chk({24'h0, d[7:0]}, 32'h00000011, "pending and lost");
		wr(fmu_pkg::ADDR_IRQ_SEL, 32'h00000000);
		wr(fmu_pkg::ADDR_IRQ_STATUS, 32'h000000ff);
		repeat (WIN + 100) @(posedge clk_i);
		chk({30'h0, hw_irq_o, diag_irq_o}, 32'h00000000, "selection none");
		$display("test interrupts done");

		hi[0] <= 12'h064;
		repeat (2 * WIN + 300) @(posedge clk_i);
		rchk(va(0), 32'h00000000, "short pulses dropped");
		wr(ca(0), cw(14'h0064, 3'h0, 0, 1, 0));
		repeat (2 * WIN + 300) @(posedge clk_i);
		rchk(va(0), 32'(WIN / 500 * 1000000 / 100), "short pulses at 1k");
		hi[0] <= 12'h01e;
		wr(ca(0), cw(14'h0064, 3'h1, 0, 1, 0));
		repeat (2 * WIN + 300) @(posedge clk_i);
		rchk(va(0), 32'(WIN / 500 * 1000000 / 100), "shorter pulses at 2k");
		$display("test filter done");

		wr(ca(1), cw(14'h0064, 3'h5, 0, 1, 1));
		wr(ca(2), cw(14'h0064, 3'h5, 0, 0, 0));
		rd(fmu_pkg::ADDR_IRQ_STATUS);
		chk({28'h0, d[11:8]}, 32'h00000009, "running bits");
		en <= 4'h0;
		repeat (2 * WIN + 300) @(posedge clk_i);
		rchk(va(0), 32'h00000000, "no edges");
		rchk(va(3), 32'h00000000, "no edges");
		rchk(va(1), 32'(WIN / 625 * 1000000 / 100), "kept under pwm");
		rchk(va(2), 32'(WIN / 1250 * 1000000 / 100), "kept with gate closed");
		$display("test pwm and gate done");
		results();
	end
endmodule
